// file: rtl/dcff_defines.vh
// constants of the dual-clock fifo flag timing block
`ifndef DCFF_DEFINES_VH
`define DCFF_DEFINES_VH

// ----------------------------------------
// timing, in ns at a 5 ns system clock
// ----------------------------------------
`define DCFF_CLK_PERIOD_NS   5
`define DCFF_SKEW_FLAG_NS    6
`define DCFF_SKEW_LEVEL_NS   15
`define DCFF_SKEW_FLAG_CYC   ((`DCFF_SKEW_FLAG_NS + `DCFF_CLK_PERIOD_NS - 1) / `DCFF_CLK_PERIOD_NS)
`define DCFF_SKEW_LEVEL_CYC  ((`DCFF_SKEW_LEVEL_NS + `DCFF_CLK_PERIOD_NS - 1) / `DCFF_CLK_PERIOD_NS)

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define DCFF_OFS_CTRL        5'h00
`define DCFF_OFS_EMPTY_OFS   5'h04
`define DCFF_OFS_FULL_OFS    5'h08
`define DCFF_OFS_STATUS      5'h0C
`define DCFF_OFS_IRQ_STAT    5'h10
`define DCFF_OFS_IRQ_MASK    5'h14

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define DCFF_OFFSET_W        13
`define DCFF_OFFSET_RST      13'h0007
`define DCFF_IRQ_W           4
`define DCFF_IRQ_FULL        0
`define DCFF_IRQ_EMPTY       1
`define DCFF_IRQ_WR_REFUSED  2
`define DCFF_IRQ_RD_REFUSED  3
`define DCFF_IRQ_MASK_RST    4'h0
`define DCFF_ST_EMPTY_N      0
`define DCFF_ST_FULL_N       1
`define DCFF_ST_AEMPTY_N     2
`define DCFF_ST_AFULL_N      3
`define DCFF_ST_LOAD_MODE    4
`define DCFF_ST_COUNT_LSB    16
`define DCFF_CTRL_LOAD_SEL   0

`endif

// file: rtl/dcff_sync.v
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module dcff_sync #(
  parameter WIDTH = 1
) (
  // clock
  input  wire             clk,
  // data
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;

  // no reset: straps and free-running clocks must be seen while reset is held
  always @(posedge clk) begin
    meta_reg <= async_in;
    sync_reg <= meta_reg;
  end

  assign sync_out = sync_reg;

endmodule

// file: rtl/dcff_mem.v
// fifo storage with registered read data
`timescale 1ns/100ps
module dcff_mem #(
  parameter DATA_W = 9,
  parameter ADDR_W = 6
) (
  // clock
  input  wire              clk,
  // write port
  input  wire              wr_en,
  input  wire [ADDR_W-1:0] wr_addr,
  input  wire [DATA_W-1:0] wr_data,
  // read port
  input  wire [ADDR_W-1:0] rd_addr,
  output reg  [DATA_W-1:0] rd_data
);

  reg [DATA_W-1:0] store [0:(1<<ADDR_W)-1];

  always @(posedge clk) begin
    if (wr_en) begin
      store[wr_addr] <= wr_data;
    end
    rd_data <= store[rd_addr];
  end

endmodule

// file: rtl/dcff_top.v
// dual-clock fifo with skew-qualified flags and avalon control
//
// Contract
// [R01] full rises on a write-clock edge only if a read is old enough
// [R02] empty rises on a read-clock edge only if a write is old enough
// [R03] write and read clocks may keep running during reset
// [R04] after reset data outputs are low when enabled, released otherwise
// [R05] second write pin high in reset makes it an extra write enable
// [R06] second write pin low in reset makes it the offset load enable
// [R07] first word latency into empty fifo is one or two clock periods
// [R08] first word is readable the read cycle after empty rises
// [R09] almost-empty follows a write only after the longer skew
// [R10] almost-empty low when fewer than n words remain
// [R11] almost-full low when within m-1 words of full
// [R12] almost-full threshold is depth minus m words
// [R13] almost-full follows a read only after the longer skew
// [R14] writes while full and reads while empty are ignored
// [R15] reset clears pointers, sets empty and almost-empty, clears full flags
`timescale 1ns/100ps
`include "dcff_defines.vh"
module dcff_top #(
  parameter DATA_W = 9,
  parameter ADDR_W = 6
) (
  // clock and reset
  input  wire              clk,
  input  wire              rst_n,
  // write side pins
  input  wire              write_clock,
  input  wire              write_enable_a_n,
  input  wire              write_enable_b_or_load,
  input  wire [DATA_W-1:0] write_data,
  // read side pins
  input  wire              read_clock,
  input  wire              read_enable_a_n,
  input  wire              read_enable_b_n,
  input  wire              output_disable,
  output reg  [DATA_W-1:0] read_data,
  output wire              read_data_oe_n,
  // flags
  output reg               full_flag_n,
  output reg               empty_flag_n,
  output reg               almost_empty_n,
  output reg               almost_full_n,
  // avalon-mm slave
  input  wire [4:0]        avs_address,
  input  wire              avs_read,
  input  wire              avs_write,
  input  wire [31:0]       avs_writedata,
  input  wire [3:0]        avs_byteenable,
  output reg  [31:0]       avs_readdata,
  output wire              avs_waitrequest,
  // interrupt
  output wire              irq
);

  localparam CNT_W  = ADDR_W + 1;
  localparam CMP_W  = `DCFF_OFFSET_W + 1;
  localparam AGE_W  = 5;
  localparam integer     DEPTH_I = (1 << ADDR_W);
  localparam integer     SKEW1_I = `DCFF_SKEW_FLAG_CYC;
  localparam integer     SKEW2_I = `DCFF_SKEW_LEVEL_CYC;
  localparam [CMP_W-1:0] DEPTH   = DEPTH_I[CMP_W-1:0];
  localparam [AGE_W-1:0] SKEW1_C = SKEW1_I[AGE_W-1:0];
  localparam [AGE_W-1:0] SKEW2_C = SKEW2_I[AGE_W-1:0];
  localparam [AGE_W-1:0] AGE_MAX = {AGE_W{1'b1}};

  // ----------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------
  localparam PIN_W = DATA_W + 7;
  wire [PIN_W-1:0] pins_sync;

  dcff_sync #(
    .WIDTH    (PIN_W)
  ) u_pin_sync (
    .clk      (clk),
    .async_in ({output_disable, read_enable_b_n, read_enable_a_n, read_clock,
                write_enable_b_or_load, write_enable_a_n, write_clock, write_data}),
    .sync_out (pins_sync)
  );

  wire [DATA_W-1:0] wdata_s  = pins_sync[DATA_W-1:0];
  wire              wclk_s   = pins_sync[DATA_W];
  wire              wen_a_s  = pins_sync[DATA_W+1];
  wire              wen_b_s  = pins_sync[DATA_W+2];
  wire              rclk_s   = pins_sync[DATA_W+3];
  wire              ren_a_s  = pins_sync[DATA_W+4];
  wire              ren_b_s  = pins_sync[DATA_W+5];
  wire              odis_s   = pins_sync[DATA_W+6];

  reg               wclk_d_reg;
  reg               rclk_d_reg;

  // edges keep being tracked in reset so clocks may run freely
  // [R03] free-running clocks
  always @(posedge clk) begin
    wclk_d_reg <= wclk_s;
    rclk_d_reg <= rclk_s;
  end

  wire wclk_rise = wclk_s & ~wclk_d_reg;
  wire rclk_rise = rclk_s & ~rclk_d_reg;

  // ----------------------------------------
  // second write pin function, caught in reset
  // ----------------------------------------
  reg load_mode_reg;

  // [R05] [R06] mode strap
  always @(posedge clk) begin
    if (!rst_n) begin
      load_mode_reg <= ~wen_b_s;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [`DCFF_OFFSET_W-1:0] empty_ofs_reg;
  reg [`DCFF_OFFSET_W-1:0] full_ofs_reg;
  reg [`DCFF_IRQ_W-1:0]    irq_stat_reg;
  reg [`DCFF_IRQ_W-1:0]    irq_mask_reg;
  reg                      load_sel_reg;
  reg                      ack_reg;

  // ----------------------------------------
  // fifo state
  // ----------------------------------------
  reg [ADDR_W-1:0] wr_ptr_reg;
  reg [ADDR_W-1:0] rd_ptr_reg;
  reg [CNT_W-1:0]  count_reg;
  reg [AGE_W-1:0]  wr_age_reg;
  reg [AGE_W-1:0]  rd_age_reg;
  reg              rd_pend_reg;

  // second pin high writes in both modes; low only loads in load mode
  wire wr_req   = wclk_rise & ~wen_a_s & wen_b_s;
  wire load_req = wclk_rise & ~wen_a_s & load_mode_reg & ~wen_b_s;
  wire rd_req   = rclk_rise & ~ren_a_s & ~ren_b_s;

  // [R14] refuse on the flag
  wire wr_do    = wr_req & full_flag_n;
  wire rd_do    = rd_req & empty_flag_n;

  wire [CMP_W-1:0] cnt_x = {{(CMP_W-CNT_W){1'b0}}, count_reg};

  // recent events are hidden from the far side until the skew has passed
  wire hide_wr1 = (wr_age_reg < SKEW1_C);
  wire hide_wr2 = (wr_age_reg < SKEW2_C);
  wire hide_rd1 = (rd_age_reg < SKEW1_C);
  wire hide_rd2 = (rd_age_reg < SKEW2_C);

  // read side views, including this edge's own read
  wire [CMP_W-1:0] rd_view1 = cnt_x - {{(CMP_W-1){1'b0}}, hide_wr1}
                                    - {{(CMP_W-1){1'b0}}, rd_do};
  wire [CMP_W-1:0] rd_view2 = cnt_x - {{(CMP_W-1){1'b0}}, hide_wr2}
                                    - {{(CMP_W-1){1'b0}}, rd_do};
  // write side views, including this edge's own write
  wire [CMP_W-1:0] wr_view1 = cnt_x + {{(CMP_W-1){1'b0}}, hide_rd1}
                                    + {{(CMP_W-1){1'b0}}, wr_do};
  wire [CMP_W-1:0] wr_view2 = cnt_x + {{(CMP_W-1){1'b0}}, hide_rd2}
                                    + {{(CMP_W-1){1'b0}}, wr_do};

  wire [CMP_W-1:0] n_x = {1'b0, empty_ofs_reg};
  wire [CMP_W-1:0] m_x = {1'b0, full_ofs_reg};

  // [R15] pointer and count clear
  always @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr_reg  <= {ADDR_W{1'b0}};
      rd_ptr_reg  <= {ADDR_W{1'b0}};
      count_reg   <= {CNT_W{1'b0}};
      wr_age_reg  <= AGE_MAX;
      rd_age_reg  <= AGE_MAX;
      rd_pend_reg <= 1'b0;
    end else begin
      if (wr_do) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (rd_do) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      count_reg   <= count_reg + {{(CNT_W-1){1'b0}}, wr_do} - {{(CNT_W-1){1'b0}}, rd_do};
      rd_pend_reg <= rd_do;
      if (wr_do) begin
        wr_age_reg <= {AGE_W{1'b0}};
      end else if (wr_age_reg != AGE_MAX) begin
        wr_age_reg <= wr_age_reg + 1'b1;
      end
      if (rd_do) begin
        rd_age_reg <= {AGE_W{1'b0}};
      end else if (rd_age_reg != AGE_MAX) begin
        rd_age_reg <= rd_age_reg + 1'b1;
      end
    end
  end

  // ----------------------------------------
  // flags
  // ----------------------------------------
  // [R15] reset flag levels
  always @(posedge clk) begin
    if (!rst_n) begin
      empty_flag_n   <= 1'b0;
      almost_empty_n <= 1'b0;
      full_flag_n    <= 1'b1;
      almost_full_n  <= 1'b1;
    end else begin
      if (rclk_rise) begin
        // [R02] [R07] empty with short skew
        empty_flag_n   <= (rd_view1 != {CMP_W{1'b0}});
        // [R09] [R10] almost-empty with long skew
        almost_empty_n <= (rd_view2 >= n_x);
      end
      if (wclk_rise) begin
        // [R01] full with short skew
        full_flag_n   <= (wr_view1 < DEPTH);
        // [R11] [R12] [R13] almost-full with long skew
        almost_full_n <= (wr_view2 <= DEPTH - m_x);
      end
    end
  end

  // ----------------------------------------
  // storage and read data
  // ----------------------------------------
  wire [DATA_W-1:0] mem_q;

  dcff_mem #(
    .DATA_W  (DATA_W),
    .ADDR_W  (ADDR_W)
  ) u_mem (
    .clk     (clk),
    .wr_en   (wr_do),
    .wr_addr (wr_ptr_reg),
    .wr_data (wdata_s),
    .rd_addr (rd_ptr_reg),
    .rd_data (mem_q)
  );

  // [R08] word appears only on a read taken after empty rose
  // [R04] outputs low after reset
  always @(posedge clk) begin
    if (!rst_n) begin
      read_data <= {DATA_W{1'b0}};
    end else if (rd_pend_reg) begin
      read_data <= mem_q;
    end
  end

  // [R04] drive control
  assign read_data_oe_n = odis_s;

  // ----------------------------------------
  // offsets: pin load sequence or bus write
  // ----------------------------------------
  wire bus_wr   = avs_write & ack_reg & (avs_byteenable != 4'h0);
  wire [2:0] widx = avs_address[4:2];

  function sel;
    input [4:0] addr;
    input [4:0] ofs;
    begin
      sel = (addr[4:2] == ofs[4:2]);
    end
  endfunction

  // [R06] load sequence: empty offset, then full offset
  always @(posedge clk) begin
    if (!rst_n) begin
      empty_ofs_reg <= `DCFF_OFFSET_RST;
      full_ofs_reg  <= `DCFF_OFFSET_RST;
      load_sel_reg  <= 1'b0;
    end else if (load_req) begin
      if (load_sel_reg) begin
        full_ofs_reg <= {{(`DCFF_OFFSET_W-DATA_W){1'b0}}, wdata_s};
      end else begin
        empty_ofs_reg <= {{(`DCFF_OFFSET_W-DATA_W){1'b0}}, wdata_s};
      end
      load_sel_reg <= ~load_sel_reg;
    end else if (bus_wr) begin
      if (sel(avs_address, `DCFF_OFS_EMPTY_OFS)) begin
        empty_ofs_reg <= avs_writedata[`DCFF_OFFSET_W-1:0];
      end
      if (sel(avs_address, `DCFF_OFS_FULL_OFS)) begin
        full_ofs_reg <= avs_writedata[`DCFF_OFFSET_W-1:0];
      end
      if (sel(avs_address, `DCFF_OFS_CTRL)) begin
        load_sel_reg <= avs_writedata[`DCFF_CTRL_LOAD_SEL];
      end
    end
  end

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  reg              full_d_reg;
  reg              empty_d_reg;
  wire [`DCFF_IRQ_W-1:0] irq_set;
  wire [`DCFF_IRQ_W-1:0] irq_clr;

  always @(posedge clk) begin
    if (!rst_n) begin
      full_d_reg  <= 1'b1;
      empty_d_reg <= 1'b0;
    end else begin
      full_d_reg  <= full_flag_n;
      empty_d_reg <= empty_flag_n;
    end
  end

  assign irq_set[`DCFF_IRQ_FULL]       = full_d_reg & ~full_flag_n;
  assign irq_set[`DCFF_IRQ_EMPTY]      = empty_d_reg & ~empty_flag_n;
  assign irq_set[`DCFF_IRQ_WR_REFUSED] = wr_req & ~full_flag_n;
  assign irq_set[`DCFF_IRQ_RD_REFUSED] = rd_req & ~empty_flag_n;
  assign irq_clr = (bus_wr && sel(avs_address, `DCFF_OFS_IRQ_STAT)) ?
                   avs_writedata[`DCFF_IRQ_W-1:0] : {`DCFF_IRQ_W{1'b0}};

  // set wins over a clear in the same cycle
  always @(posedge clk) begin
    if (!rst_n) begin
      irq_stat_reg <= {`DCFF_IRQ_W{1'b0}};
      irq_mask_reg <= `DCFF_IRQ_MASK_RST;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
      if (bus_wr && sel(avs_address, `DCFF_OFS_IRQ_MASK)) begin
        irq_mask_reg <= avs_writedata[`DCFF_IRQ_W-1:0];
      end
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  // ----------------------------------------
  // avalon slave: one wait cycle per access
  // ----------------------------------------
  reg [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h0000_0000;
    case (widx)
      3'h0: rd_mux[`DCFF_CTRL_LOAD_SEL] = load_sel_reg;
      3'h1: rd_mux[`DCFF_OFFSET_W-1:0] = empty_ofs_reg;
      3'h2: rd_mux[`DCFF_OFFSET_W-1:0] = full_ofs_reg;
      3'h3: begin
        rd_mux[`DCFF_ST_EMPTY_N]   = empty_flag_n;
        rd_mux[`DCFF_ST_FULL_N]    = full_flag_n;
        rd_mux[`DCFF_ST_AEMPTY_N]  = almost_empty_n;
        rd_mux[`DCFF_ST_AFULL_N]   = almost_full_n;
        rd_mux[`DCFF_ST_LOAD_MODE] = load_mode_reg;
        rd_mux[`DCFF_ST_COUNT_LSB +: CNT_W] = count_reg;
      end
      3'h4: rd_mux[`DCFF_IRQ_W-1:0] = irq_stat_reg;
      3'h5: rd_mux[`DCFF_IRQ_W-1:0] = irq_mask_reg;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      ack_reg      <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      ack_reg <= (avs_read | avs_write) & ~ack_reg;
      if (avs_read & ~ack_reg) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;

endmodule

// file: test/dcff_properties.sv
// concurrent checks on the fifo top ports
`timescale 1ns/100ps
module dcff_properties #(
  parameter DATA_W = 9
) (
  // clock and reset
  input wire              clk,
  input wire              rst_n,
  // pins
  input wire              write_enable_a_n,
  input wire              read_enable_b_n,
  input wire              output_disable,
  input wire [DATA_W-1:0] read_data,
  input wire              read_data_oe_n,
  input wire              full_flag_n,
  input wire              empty_flag_n,
  input wire              almost_empty_n,
  input wire              almost_full_n,
  // bus
  input wire              avs_read,
  input wire              avs_write,
  input wire [31:0]       avs_readdata,
  input wire              avs_waitrequest
);
  // ----------------------
  // pin and bus properties
  // ----------------------
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  reset_flags_a: assert property (disable iff (1'b0)
    !rst_n |=> !empty_flag_n && !almost_empty_n && full_flag_n && almost_full_n)
    else $error("flags wrong in reset");
  flag_excl_a: assert property (!(!full_flag_n && !empty_flag_n))
    else $error("full and empty together");
  full_af_a: assert property (!full_flag_n |-> !almost_full_n)
    else $error("full without almost full");
  empty_ae_a: assert property (!empty_flag_n |-> !almost_empty_n)
    else $error("empty without almost empty");
  full_cause_a: assert property ($fell(full_flag_n) |-> $past(write_enable_a_n, 4) == 1'b0)
    else $error("full without a write");
  empty_cause_a: assert property ($fell(empty_flag_n) |-> $past(read_enable_b_n, 4) == 1'b0)
    else $error("empty without a read");
  rdata_cause_a: assert property (!$stable(read_data) |-> $past(read_enable_b_n, 5) == 1'b0)
    else $error("read data moved without a read");
  oe_follow_a: assert property ($changed(output_disable)
    |-> ##[1:4] (read_data_oe_n == output_disable))
    else $error("output enable not following");
  wait_first_a: assert property ($rose(avs_read) || $rose(avs_write) |-> avs_waitrequest)
    else $error("no wait state");
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait longer than one cycle");
  rd_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data changed unasked");
endmodule

bind dcff_top dcff_properties #(.DATA_W(DATA_W)) chk (.*);

// file: test/dcff_link_model.sv
// writer and reader controllers on their own free-running clocks
`timescale 1ns/100ps
module dcff_link_model (
  // requests from the bench
  input wire       wr_on,
  input wire       rd_on,
  // fifo pins
  output reg       write_clock,
  output reg       write_enable_a_n,
  output reg [8:0] write_data,
  output reg       read_clock,
  output reg       read_enable_a_n,
  output reg       read_enable_b_n
);
  // -----------
  // pin drivers
  // -----------
  reg [8:0] seq;

  initial begin
    write_clock = 1'b0;
    write_enable_a_n = 1'b1;
    seq = 9'h0A5;
    write_data = 9'h1FF;
    #7.3;
    forever #80 write_clock = ~write_clock;
  end
  initial begin
    read_clock = 1'b0;
    read_enable_a_n = 1'b1;
    read_enable_b_n = 1'b1;
    #41.9;
    forever #80 read_clock = ~read_clock;
  end
  // change mid-period; idle data inverted so a stale word cannot pass
  always @(negedge write_clock) begin
    write_enable_a_n <= ~wr_on;
    write_data <= wr_on ? seq : ~seq;
  end
  always @(posedge write_clock) begin
    if (!write_enable_a_n)
      seq <= seq + 9'h001;
  end
  always @(negedge read_clock) begin
    read_enable_a_n <= ~rd_on;
    read_enable_b_n <= ~rd_on;
  end
endmodule

// file: test/dcff_top_tb.sv
// self-checking bench of the dual-clock fifo flags and registers
`timescale 1ns/100ps
`include "dcff_defines.vh"
module dcff_top_tb;
  // -------
  // signals
  // -------
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        wr_on = 1'b0;
  logic        rd_on = 1'b0;
  logic        write_enable_b_or_load = 1'b1;
  logic        output_disable = 1'b0;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] q;
  wire  [31:0] avs_readdata;
  wire  [8:0]  write_data, read_data;
  wire         write_clock, write_enable_a_n, read_clock, read_enable_a_n, read_enable_b_n;
  wire         read_data_oe_n, full_flag_n, empty_flag_n, almost_empty_n, almost_full_n;
  wire         avs_waitrequest, irq;
  int          fail_count = 0, tests_run = 0, cyc = 0, seq = 9'h0A5, nxt = 9'h0A5;

  always #2.5 clk = ~clk;
  dcff_link_model link (.*);
  dcff_top dut (.*);

  // -----
  // tasks
  // -----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      conclude();
    end
  end

  task automatic do_reset;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
  endtask

  // request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~wr;
    avs_write <= wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic push(input int k);
    @(posedge clk);
    wr_on <= 1'b1;
    repeat (k) @(posedge write_clock iff !write_enable_a_n);
    @(posedge clk);
    wr_on <= 1'b0;
    seq += k;
    repeat (12) @(posedge clk);
  endtask

  task automatic pop(input int k);
    @(posedge clk);
    rd_on <= 1'b1;
    repeat (k) begin
      @(posedge read_clock iff !read_enable_a_n);
      repeat (8) @(posedge clk);
      chk(read_data, nxt, "read word");
      nxt++;
    end
    rd_on <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  // ---------
  // scenarios
  // ---------
  task automatic t_reset;
    chk({empty_flag_n, almost_empty_n, full_flag_n, almost_full_n}, 4'h3, "reset flags");
    chk(read_data, 0, "reset data");
    chk(read_data_oe_n, 0, "outputs driven");
    output_disable <= 1'b1;
    repeat (6) @(posedge clk);
    chk(read_data_oe_n, 1, "outputs released");
    output_disable <= 1'b0;
    bus(0, `DCFF_OFS_STATUS, 0);
    chk(q[`DCFF_ST_LOAD_MODE], 0, "enable mode");
    bus(0, `DCFF_OFS_EMPTY_OFS, 0);
    chk(q, `DCFF_OFFSET_RST, "offset reset");
    bus(0, 5'h1C, 0);
    chk(q, 0, "unmapped read");
  endtask

  task automatic t_first;
    int n;
    n = 0;
    push(1);
    // one link period plus skew and sync, less the time push already waited
    while (empty_flag_n !== 1'b1 && n < 60) begin
      @(posedge clk);
      n++;
    end
    chk(n <= 27, 1, "first word late");
    pop(1);
  endtask

  task automatic t_fill;
    push(57);
    chk(almost_full_n, 1, "almost full early");
    push(1);
    chk(almost_full_n, 0, "almost full missing");
    push(6);
    chk(full_flag_n, 0, "not full");
    chk(almost_empty_n, 1, "almost empty stuck");
    push(1);
    bus(0, `DCFF_OFS_STATUS, 0);
    chk(q[22:16], 64, "count after refused write");
    bus(0, `DCFF_OFS_IRQ_STAT, 0);
    chk(q[`DCFF_IRQ_WR_REFUSED], 1, "refusal not flagged");
    bus(1, `DCFF_OFS_IRQ_MASK, 32'h00000004);
    @(posedge clk);
    chk(irq, 1, "irq not raised");
    bus(1, `DCFF_OFS_IRQ_STAT, 32'h00000004);
    @(posedge clk);
    chk(irq, 0, "irq not cleared");
  endtask

  task automatic t_drain;
    int n;
    n = 0;
    pop(1);
    while (full_flag_n !== 1'b1 && n < 60) begin
      @(posedge clk);
      n++;
    end
    chk(n <= 26, 1, "full release late");
    pop(56);
    chk(almost_empty_n, 1, "almost empty early");
    chk(almost_full_n, 1, "almost full stuck");
    pop(1);
    chk(almost_empty_n, 0, "almost empty missing");
    pop(6);
    chk(empty_flag_n, 0, "not empty");
    rd_on <= 1'b1;
    @(posedge read_clock iff !read_enable_a_n);
    repeat (8) @(posedge clk);
    rd_on <= 1'b0;
    chk(read_data, nxt - 1, "data moved on refused read");
    bus(0, `DCFF_OFS_IRQ_STAT, 0);
    chk(q[`DCFF_IRQ_RD_REFUSED], 1, "read refusal not flagged");
  endtask

  task automatic t_load;
    int d;
    write_enable_b_or_load <= 1'b0;
    repeat (4) @(posedge clk);
    do_reset;
    bus(0, `DCFF_OFS_STATUS, 0);
    chk(q[`DCFF_ST_LOAD_MODE], 1, "load mode");
    d = seq;
    push(1);
    bus(0, `DCFF_OFS_EMPTY_OFS, 0);
    chk(q, d & 32'h000001FF, "offset not loaded");
    chk(empty_flag_n, 0, "load went to fifo");
    bus(0, `DCFF_OFS_CTRL, 0);
    chk(q, 1, "load select not advanced");
    d = seq;
    push(1);
    // a write with no byte lanes must leave the loaded offset alone
    avs_byteenable <= 4'h0;
    bus(1, `DCFF_OFS_FULL_OFS, 32'h00000015);
    avs_byteenable <= 4'hF;
    bus(0, `DCFF_OFS_FULL_OFS, 0);
    chk(q, d & 32'h000001FF, "full offset not loaded");
  endtask

  initial begin
    do_reset;
    t_reset;
    t_first;
    t_fill;
    t_drain;
    t_load;
    conclude;
  end
endmodule
